/* File: hdl/esq_led_ctrl.sv */
// Tricolour LED indicator for main track and reference index quality
`timescale 1ns/1ps
`default_nettype none

// The quality grades arrive already judged; this block only maps them to
// colours, blinks them and arbitrates between the main-track indication and
// the short reference-mark indication. LED drive is active high per colour.
// Limitation: the blink phase runs free, so the first lit half of an
// indication may be shortened by up to one blink half period.

// Overview of operation
// - Stand-alone, very good signals: steady green
// - Stand-alone, good signals: blinking green
// - Stand-alone, out of tolerance: blinking red
// - Reference index in tolerance: blinking blue
// - Reference index out of tolerance: blinking red
// - Test box: steady green, main evaluation off
// - Mark within hold-off: no reference report
// - Hold-off keeps main indication visible
module esq_led_ctrl #(
    // Half blink period in clock cycles
    parameter int unsigned BLINK_HALF = esq_pkg::BLINK_HALF_CYC,
    // Length of a reference indication in clock cycles
    parameter int unsigned REF_SHOW = esq_pkg::REF_SHOW_CYC,
    // Reference hold-off in clock cycles
    parameter int unsigned HOLDOFF = esq_pkg::HOLDOFF_CYC
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic test_box_present,
    input wire esq_pkg::esq_qual_e main_quality,
    input wire esq_pkg::esq_ref_s reference_index,
    output var esq_pkg::esq_led_s led_ff
);

    // Blink phase divider count
    logic [esq_pkg::CNT_W-1:0] blink_cnt_ff;
    // Blink phase, high means lit
    logic blink_ff;
    // Display state
    esq_pkg::esq_state_e state_ff;
    // Next display state
    esq_pkg::esq_state_e nxt_state;
    // Next LED value
    esq_pkg::esq_led_s nxt_led;
    // Main-track colour for this cycle
    esq_pkg::esq_led_s main_led;
    // Good-mark colour for this cycle
    esq_pkg::esq_led_s ok_led;
    // Bad-mark colour for this cycle
    esq_pkg::esq_led_s bad_led;
    // Display sits in the main-track state
    logic in_main;
    // Hold-off running since last mark
    logic hold_busy;
    // Reference display still running
    logic show_busy;
    // Mark accepted for display
    logic ref_accept;
    // Blink phase end pulse
    wire blink_tick = (blink_cnt_ff == esq_pkg::CNT_W'(BLINK_HALF - 1));

    // Main-track colour for one blink phase; the test box masks the grade
    function automatic esq_pkg::esq_led_s main_colour
    (
        logic box,
        esq_pkg::esq_qual_e grade,
        logic phase
    );
        // Colour being built
        esq_pkg::esq_led_s col;
        col = esq_pkg::LED_OFF;
        if (box)
            col.green = 1'h1;
        else if (grade == esq_pkg::ESQ_Q_VGOOD)
            col.green = 1'h1;
        else if (grade == esq_pkg::ESQ_Q_GOOD)
            col.green = phase;
        else
            col.red = phase;
        return col;
    endfunction

    // Reference colour for one blink phase: blue in tolerance, else red
    function automatic esq_pkg::esq_led_s ref_colour
    (
        logic in_tol,
        logic phase
    );
        // Colour being built
        esq_pkg::esq_led_s col;
        col = esq_pkg::LED_OFF;
        if (in_tol)
            col.blue = phase;
        else
            col.red = phase;
        return col;
    endfunction

    // Main-track indication for the present blink phase
    assign main_led = main_colour(test_box_present, main_quality, blink_ff);
    // Good-mark indication, the same in both modes
    assign ok_led = ref_colour(1'h1, blink_ff);
    // Bad-mark indication, the same in both modes
    assign bad_led = ref_colour(1'h0, blink_ff);

    // Marks are only taken while the main-track indication is on the LED
    assign in_main = (state_ff == esq_pkg::ESQ_ST_MAIN);

    // Every mark restarts the hold-off, so a dense train of marks shows only its first mark.
    // A mark during a running display is dropped as well: otherwise marks
    // spaced just beyond the hold-off would restart the display for ever and
    // hide the main-track indication.
    assign ref_accept = reference_index.pass && !hold_busy && in_main;

    // Hold-off timer, restarted by every passed mark.
    // Refused marks retrigger it too, so the hold-off is measured from the
    // last mark seen, shown or not.
    esq_interval #(
        .LEN(HOLDOFF)
    ) u_holdoff (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(reference_index.pass),
        .busy(hold_busy)
    );

    // Reference indication length timer
    // Started by accepted marks only, so a display is never stretched
    esq_interval #(
        .LEN(REF_SHOW)
    ) u_show (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(ref_accept),
        .busy(show_busy)
    );

    // Blink divider: one enable pulse per half period.
    // The phase is shared by every blinking colour, so a change of colour
    // never restarts the blink and the rhythm stays even on the LED.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Start lit, counter at the beginning of a half period
            blink_cnt_ff <= '0;
            blink_ff <= 1'h1;
        end
        else if (blink_tick)
        begin
            blink_cnt_ff <= '0;
            blink_ff <= ~blink_ff;
        end
        else
            blink_cnt_ff <= blink_cnt_ff + 1'h1;
    end

    // Reference display overrides main track, then falls back to it
    // Marks reach the reference states only through ref_accept
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            esq_pkg::ESQ_ST_MAIN:
            begin
                // Accepted mark takes over the LED
                // Verdict is taken in the same cycle as the mark
                if (ref_accept)
                    nxt_state = reference_index.in_tol ? esq_pkg::ESQ_ST_REF_OK
                                                       : esq_pkg::ESQ_ST_REF_BAD;
            end
            esq_pkg::ESQ_ST_REF_OK, esq_pkg::ESQ_ST_REF_BAD:
            begin
                // Return once the show time runs out
                if (!show_busy)
                    nxt_state = esq_pkg::ESQ_ST_MAIN;
            end
            default:
                nxt_state = esq_pkg::ESQ_ST_MAIN;
        endcase
    end

    // LED colour selection; the reference display takes precedence
    always_comb
    begin
        nxt_led = esq_pkg::LED_OFF;
        case (state_ff)
            // Good mark on show
            esq_pkg::ESQ_ST_REF_OK:
                nxt_led = ok_led;
            // Bad mark on show
            esq_pkg::ESQ_ST_REF_BAD:
                nxt_led = bad_led;
            // Main-track or power indication
            esq_pkg::ESQ_ST_MAIN:
                nxt_led = main_led;
            // Unused state code keeps the LED dark
            default:
                nxt_led = esq_pkg::LED_OFF;
        endcase
    end

    // State and LED registers; LED output comes straight from a flop
    // The extra cycle of latency is traded for a glitch-free LED drive
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // LED dark while reset is held
            state_ff <= esq_pkg::ESQ_ST_MAIN;
            led_ff <= esq_pkg::LED_OFF;
        end
        else
        begin
            // One cycle from quality and test box inputs to LED, two from a mark via state_ff
            state_ff <= nxt_state;
            led_ff <= nxt_led;
        end
    end

endmodule // esq_led_ctrl

`default_nettype wire

/* File: hdl/esq_pkg.sv */
// Package for the encoder signal quality LED indicator
package esq_pkg;

    // Clock rate of clk_sys in Hz
    localparam int unsigned CLK_HZ = 20000000;
    // Reference hold-off time in ms
    localparam int unsigned HOLDOFF_MS = 500;
    // Hold-off in clock cycles, exact at this clock rate
    localparam int unsigned HOLDOFF_CYC = (HOLDOFF_MS * (CLK_HZ / 1000));
    // Default half blink period in ms
    localparam int unsigned BLINK_HALF_MS = 125;
    // Default half blink period in cycles
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    // Default reference indication length in ms
    localparam int unsigned REF_SHOW_MS = 1000;
    // Default reference indication length in cycles
    localparam int unsigned REF_SHOW_CYC = REF_SHOW_MS * (CLK_HZ / 1000);
    // Counter width for all long intervals
    localparam int unsigned CNT_W = 25;

    // Main track quality grades
    typedef enum logic [1:0]
    {
        ESQ_Q_FAIL = 2'h0,
        ESQ_Q_GOOD = 2'h1,
        ESQ_Q_VGOOD = 2'h2
    } esq_qual_e;

    // Display selector state
    typedef enum logic [1:0]
    {
        ESQ_ST_MAIN = 2'h0,
        ESQ_ST_REF_OK = 2'h1,
        ESQ_ST_REF_BAD = 2'h2
    } esq_state_e;

    // LED drive, one bit per colour
    typedef struct packed
    {
        logic red;
        logic green;
        logic blue;
    } esq_led_s;

    // Reference mark event with its verdict
    typedef struct packed
    {
        logic pass;
        logic in_tol;
    } esq_ref_s;

    // All LEDs off
    localparam esq_led_s LED_OFF = 3'h0;

endpackage

/* File: hdl/esq_interval.sv */
// Restartable down counter that flags when an interval is running
`timescale 1ns/1ps
`default_nettype none

module esq_interval #(
    parameter int unsigned LEN = 4
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    output logic busy
);

    // Remaining cycles of the interval
    logic [esq_pkg::CNT_W-1:0] left_ff;
    // Next remaining count
    logic [esq_pkg::CNT_W-1:0] nxt_left;

    // Restart loads the full length, otherwise count down to zero
    assign nxt_left = start ? esq_pkg::CNT_W'(LEN) :
                      (left_ff != '0) ? left_ff - 1'h1 : left_ff;
    assign busy = (left_ff != '0);

    // Counter register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            left_ff <= '0;
        else
            left_ff <= nxt_left;
    end

endmodule // esq_interval

`default_nettype wire

/* File: sim/esq_led_ctrl_assertions.sv */
// Checker for the LED indicator
`timescale 1ns/1ps
`default_nettype none
module esq_chk #(
    parameter int unsigned BLINK_HALF = 2,
    parameter int unsigned REF_SHOW = 8,
    parameter int unsigned HOLDOFF = 30
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic test_box_present,
    input wire esq_pkg::esq_qual_e main_quality,
    input wire esq_pkg::esq_ref_s reference_index,
    input wire esq_pkg::esq_led_s led_ff
);
    // Quiet once both hold-off and display have surely ended
    localparam int QT = (HOLDOFF > REF_SHOW ? HOLDOFF : REF_SHOW) + 2;
    int since_ff; // Cycles since last mark
    int run_ff; // Cycles the LED stood still
    logic [1:0] q_ff; // Quality seen last edge
    logic tb_ff; // Test box seen last edge
    wire quiet = since_ff >= QT;
    wire blink_c = quiet && !tb_ff && q_ff != 2'h2;
    wire fail_c = blink_c && q_ff != 2'h1;
    // Helper history, cleared by reset
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            since_ff <= 0;
            run_ff <= 0;
            q_ff <= 2'h0;
            tb_ff <= 1'b0;
        end
        else
        begin
            since_ff <= reference_index.pass ? 0 : (quiet ? since_ff : since_ff + 1);
            run_ff <= (blink_c && $stable(led_ff)) ? run_ff + 1 : 0;
            q_ff <= main_quality;
            tb_ff <= test_box_present;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_take(bit ok); reference_index.pass && quiet && reference_index.in_tol == ok; endsequence
    property p_vgood; quiet && !tb_ff && q_ff == 2'h2 |-> led_ff == 3'h2; endproperty
    a_vgood: assert property (p_vgood) else $error("no steady green");
    property p_good; blink_c && q_ff == 2'h1 |-> !led_ff.red && !led_ff.blue; endproperty
    a_good: assert property (p_good) else $error("bad colour");
    property p_blink; blink_c |-> run_ff <= BLINK_HALF; endproperty
    a_blink: assert property (p_blink) else $error("no blink");
    property p_fail; fail_c |-> !led_ff.green && !led_ff.blue; endproperty
    a_fail: assert property (p_fail) else $error("bad colour");
    property p_box; quiet && tb_ff |-> led_ff == 3'h2; endproperty
    a_box: assert property (p_box) else $error("no power green");
    property p_ok; s_take(1) |-> ##2 (!led_ff.red && !led_ff.green) [*3]; endproperty
    a_ok: assert property (p_ok) else $error("no blue");
    property p_bad; s_take(0) |-> ##2 (!led_ff.green && !led_ff.blue) [*3]; endproperty
    a_bad: assert property (p_bad) else $error("no red");
    property p_skip; reference_index.pass && since_ff > REF_SHOW + 2 && since_ff < HOLDOFF
        |-> ##2 !led_ff.blue [*3]; endproperty
    a_skip: assert property (p_skip) else $error("mark shown");
endmodule // esq_chk
bind esq_led_ctrl esq_chk #(.BLINK_HALF(BLINK_HALF), .REF_SHOW(REF_SHOW), .HOLDOFF(HOLDOFF))
    esq_chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .test_box_present(test_box_present),
    .main_quality(main_quality), .reference_index(reference_index), .led_ff(led_ff));
`default_nettype wire

/* File: sim/esq_led_viewer.sv */
// Observer watching the status LED
`timescale 1ns/1ps
`default_nettype none
module esq_led_viewer
(
    input wire logic clk_sys,
    input wire esq_pkg::esq_led_s led,
    input wire logic look,
    output logic [5:0] seen,
    output logic done
);
    int cnt = 0; // Samples left, two half blinks
    // Note lit and dark sightings per colour
    always @(posedge clk_sys)
    begin
        done <= cnt == 1;
        if (look)
        begin
            cnt <= 4;
            seen <= 6'h0;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            seen <= seen | {led.red, !led.red, led.green, !led.green, led.blue, !led.blue};
        end
    end
endmodule // esq_led_viewer
`default_nettype wire

/* File: sim/esq_led_ctrl_tb.sv */
// Bench for the LED indicator
`timescale 1ns/1ps
`default_nettype none
module encoder_signal_quality_led_tb;
    logic clk_sys = 0, reset_n = 0, tb = 0, look = 0, done;
    esq_pkg::esq_qual_e q = esq_pkg::ESQ_Q_VGOOD;
    esq_pkg::esq_ref_s ref_mark = 2'h0;
    esq_pkg::esq_led_s led;
    logic [5:0] seen, exp_q[$];
    int mismatches = 0, compares = 0;
    esq_led_ctrl #(.BLINK_HALF(2), .REF_SHOW(8), .HOLDOFF(30)) esq_led_ctrl_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .test_box_present(tb), .main_quality(q), .reference_index(ref_mark),
        .led_ff(led));
    esq_led_viewer esq_led_viewer_i (.clk_sys(clk_sys), .led(led), .look(look), .seen(seen),
        .done(done));
    initial forever #25 clk_sys = ~clk_sys;
    task automatic check(logic [5:0] got, logic [5:0] want);
        compares++;
        if (got !== want)
        begin
            mismatches++;
            $display("Error at %0t: led %b want %b", $time, got, want);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Note the expected sighting, then look
    task automatic view(logic [5:0] want, int n);
        repeat (n) @(posedge clk_sys);
        exp_q.push_back(want);
        look <= 1;
        @(posedge clk_sys);
        look <= 0;
        repeat (6) @(posedge clk_sys);
    endtask
    // One-cycle mark with its verdict
    task automatic mark(logic ok);
        ref_mark <= {1'h1, ok};
        @(posedge clk_sys);
        ref_mark <= 2'h0;
    endtask
    // Watcher comparing each sighting with the oldest note
    initial
    begin
        for (int i = 0; i < 1500; i++)
        begin
            @(posedge clk_sys);
            if (done === 1'b1)
                check(seen, exp_q.pop_front());
        end
        mismatches++;
        end_sim;
    end
    initial
    begin
        logic [2:0] pick; // Test box and grade of one step
        logic [5:0] exp_led; // Expected sightings for that step
        void'($urandom(32'hB2AC));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1;
        repeat (34) @(posedge clk_sys);
        // Every box and grade pair in turn, then random pairs
        for (int i = 0; i < 16; i++)
        begin
            pick = (i < 8) ? 3'(i) : 3'($urandom_range(7));
            tb <= pick[2];
            q <= esq_pkg::esq_qual_e'(pick[1:0]);
            exp_led = pick[2] || pick[1:0] == 2 ? 6'h19 : (pick[1:0] == 1 ? 6'h1D : 6'h35);
            view(exp_led, 2);
        end
        q <= esq_pkg::ESQ_Q_VGOOD;
        for (int i = 0; i < 4; i++)
        begin
            tb <= i[1];
            repeat (34 + $urandom_range(5)) @(posedge clk_sys);
            mark(i[0]);
            view(i[0] ? 6'h17 : 6'h35, 0);
            view(6'h19, 4);
            mark(1'b1);
            view(6'h19, 0);
        end
        repeat (8) @(posedge clk_sys);
        // A note never matched by a sighting counts as a miss
        if (exp_q.size() != 0)
            mismatches++;
        end_sim;
    end
endmodule // encoder_signal_quality_led_tb
`default_nettype wire
